// ### pssq_pkg.sv
// Package: constants and types for the power-state and reset sequencer
package pssq_pkg;
    // ****************************************
    // Clocking
    // ****************************************
    localparam int SYS_CLK_HZ = 20000000;
    localparam int LOW_FREQ_OSC_HZ = 380000;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Widths, cycle counts and reset values
    // ****************************************
    localparam int WAKEUP_CNT_WIDTH = 16;
    localparam logic [15:0] WAKEUP_CNT_RESET = 16'h0000;
    localparam int CFG_LOAD_CYCLES = 8;
    localparam logic [3:0] CFG_CNT_RESET = 4'h0;

    // Threshold selection encoding: 0 selects 2.3 V, 1 selects 2.75 V
    localparam logic THR_SEL_LOW = 1'b0;
    localparam logic THR_SEL_HIGH = 1'b1;

    // ****************************************
    // Power states
    // ****************************************
    typedef enum logic [2:0] {
        PSSQ_HPD,
        PSSQ_CFG_LOAD,
        PSSQ_ACTIVE,
        PSSQ_STANDBY,
        PSSQ_MONITOR
    } pssq_state_t;
endpackage

// ### pssq_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pssq_sync
    import pssq_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] async_in, // Asynchronous levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage; no reset so metastability never reaches logic
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ### pssq_wakeup_counter.sv
// Wake-up counter ticked by low-frequency oscillator events
`timescale 1ns/100ps
module pssq_wakeup_counter
    import pssq_pkg::*;
#(
    parameter int WIDTH = WAKEUP_CNT_WIDTH
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic run, // Count while high
    input wire logic tick, // One-cycle low-freq tick
    input wire logic [WIDTH-1:0] period, // Ticks until expiry
    output logic expired // One-cycle expiry pulse
);
    logic [WIDTH-1:0] cnt_ff;

    // Counts low-freq ticks; restarts whenever run drops
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= WAKEUP_CNT_RESET[WIDTH-1:0];
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (!run) begin
                cnt_ff <= WAKEUP_CNT_RESET[WIDTH-1:0];
            end else if (tick) begin
                if (cnt_ff + 1'b1 >= period) begin
                    cnt_ff <= WAKEUP_CNT_RESET[WIDTH-1:0];
                    expired <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end
endmodule

// ### pssq_top.sv
// Power-state and reset sequencer: top level
`timescale 1ns/100ps
module pssq_top
    import pssq_pkg::*;
#(
    parameter int WAKEUP_W = WAKEUP_CNT_WIDTH,
    parameter int CFG_CYCLES = CFG_LOAD_CYCLES
) (
    input wire logic REF_CLK, // 20 MHz low-power oscillator
    input wire logic SRST, // Synchronous reset, active high
    input wire logic CE, // Clock enable
    input wire logic CHIP_ENABLE_PIN, // Async chip-enable level
    input wire logic BAT_BELOW_2V3, // Async comparator, below 2.3 V less hysteresis
    input wire logic BAT_BELOW_2V75, // Async comparator, below 2.75 V less hysteresis
    input wire logic BAT_SUPPLY_OK, // Async battery supply present
    input wire logic PAD_SUPPLY_OK, // Async pad supply present
    input wire logic LOW_FREQ_OSC_TICK, // One-cycle tick per low-freq period
    input wire logic CFG_MON_EN, // Loaded config: supervision enable
    input wire logic CFG_THR_SEL, // Loaded config: 0=2.3 V, 1=2.75 V
    input wire logic CFG_LOADED, // Config load done pulse or level
    input wire logic STANDBY_REQ, // Firmware requests Standby
    input wire logic [WAKEUP_W-1:0] WAKEUP_PERIOD, // Wake-up period in low-freq ticks
    input wire logic NVM_WRITE_REQ, // Config memory write request
    output logic CORE_RESET, // Holds firmware and registers in reset
    output logic CFG_LOAD_REQ, // Requests default reload from config
    output logic NVM_WRITE_STROBE, // Write timing strobe, low-freq paced
    output logic MON_ACTIVE, // Battery supervision enabled
    output logic BAT_CRITICAL, // Battery critical indication
    output logic IN_STANDBY, // Standby state flag
    output logic IN_MONITOR, // Monitor state flag
    output logic IN_HPD, // Hard Power Down flag
    output logic WAKEUP_EVENT, // Standby to Active wake-up pulse
    output logic PAD_LOST // Pad supply dropped while enabled
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [4:0] async_lv;
    logic [4:0] sync_lv;
    logic en_s;
    logic b23_s;
    logic b275_s;
    logic bat_ok_s;
    logic pad_ok_s;

    assign async_lv = {PAD_SUPPLY_OK, BAT_SUPPLY_OK, BAT_BELOW_2V75, BAT_BELOW_2V3, CHIP_ENABLE_PIN};

    // Pins cross into the 20 MHz domain before any decision
    pssq_sync #(.WIDTH(5)) pssq_sync_i (
        .clk(REF_CLK),
        .ce(CE),
        .async_in(async_lv),
        .sync_out(sync_lv)
    );

    // Bit order follows the packing of async_lv
    assign en_s = sync_lv[0];
    assign b23_s = sync_lv[1];
    assign b275_s = sync_lv[2];
    assign bat_ok_s = sync_lv[3];
    assign pad_ok_s = sync_lv[4];

    // ****************************************
    // Battery supervision
    // ****************************************
    logic mon_en_ff;
    logic crit_ff;
    logic sel_below;

    // Enable latched only after config load; cleared when the enable pin drops, not on a battery-loss power down
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            mon_en_ff <= 1'b0;
        end else if (CE) begin
            if (!en_s) begin
                mon_en_ff <= 1'b0;
            end else if (CFG_LOADED) begin
                mon_en_ff <= CFG_MON_EN;
            end
        end
    end

    // Threshold mux; hysteresis lives in the analog comparator itself
    assign sel_below = (CFG_THR_SEL == THR_SEL_HIGH) ? b275_s : b23_s;

    // One flop of latency buys a clean flag that never glitches on the mux
    // Evaluated every cycle in every state, not sampled per state
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            crit_ff <= 1'b0;
        end else if (CE) begin
            crit_ff <= mon_en_ff & sel_below;
        end
    end

    // ****************************************
    // Wake-up counter
    // ****************************************
    pssq_state_t state_ff;
    pssq_state_t nxt_state;
    logic wake;
    logic stby_run;

    // Counter runs only in Standby, so each entry restarts the full period
    assign stby_run = (state_ff == PSSQ_STANDBY);

    pssq_wakeup_counter #(.WIDTH(WAKEUP_W)) pssq_wakeup_counter_i (
        .clk(REF_CLK),
        .srst(SRST),
        .ce(CE),
        .run(stby_run),
        .tick(LOW_FREQ_OSC_TICK),
        .period(WAKEUP_PERIOD),
        .expired(wake)
    );

    // ****************************************
    // Power state machine
    // ****************************************
    logic [3:0] cfg_cnt_ff;
    logic cfg_done;

    // Loader pulse or bounded wait; a silent loader cannot hang the boot
    assign cfg_done = (cfg_cnt_ff >= 4'(CFG_CYCLES)) || CFG_LOADED;

    // Enable pin dominates everything; battery only matters while enabled
    always_comb begin
        nxt_state = state_ff;
        if (!en_s || !bat_ok_s) begin
            nxt_state = PSSQ_HPD;
        end else begin
            case (state_ff)
                PSSQ_HPD: begin
                    // No battery gate here; supervision is cleared only if enable dropped
                    nxt_state = PSSQ_CFG_LOAD;
                end
                PSSQ_CFG_LOAD: begin
                    // A low battery found during reload goes straight to Monitor
                    if (crit_ff) begin
                        nxt_state = PSSQ_MONITOR;
                    end else if (cfg_done) begin
                        nxt_state = PSSQ_ACTIVE;
                    end
                end
                PSSQ_ACTIVE: begin
                    if (crit_ff) begin
                        nxt_state = PSSQ_MONITOR;
                    end else if (STANDBY_REQ) begin
                        nxt_state = PSSQ_STANDBY;
                    end
                end
                PSSQ_STANDBY: begin
                    // Low battery outranks a wake-up in the same cycle
                    if (crit_ff) begin
                        nxt_state = PSSQ_MONITOR;
                    end else if (wake) begin
                        nxt_state = PSSQ_ACTIVE;
                    end
                end
                PSSQ_MONITOR: begin
                    // Recovery reloads defaults before running again
                    if (!crit_ff) begin
                        nxt_state = PSSQ_CFG_LOAD;
                    end
                end
                default: begin
                    nxt_state = PSSQ_HPD;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_ff <= PSSQ_HPD;
        end else if (CE) begin
            state_ff <= nxt_state;
        end
    end

    // Bounded wait for defaults to reload after each reset exit
    // Saturates at the limit so the wait cannot wrap and start over
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cfg_cnt_ff <= CFG_CNT_RESET;
        end else if (CE) begin
            if (state_ff != PSSQ_CFG_LOAD) begin
                cfg_cnt_ff <= CFG_CNT_RESET;
            end else if (cfg_cnt_ff < 4'(CFG_CYCLES)) begin
                cfg_cnt_ff <= cfg_cnt_ff + 4'h1;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic core_rst_nxt;

    // Reset held only in Hard Power Down and Monitor, so firmware restarts on leaving either
    assign core_rst_nxt = (nxt_state == PSSQ_HPD) || (nxt_state == PSSQ_MONITOR);

    // Core reset and reload request follow the next state, aligned with state_ff
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            CORE_RESET <= 1'b1;
            CFG_LOAD_REQ <= 1'b0;
        end else if (CE) begin
            CORE_RESET <= core_rst_nxt;
            CFG_LOAD_REQ <= (nxt_state == PSSQ_CFG_LOAD);
        end
    end

    // Supervision status mirrors, one cycle behind the internal flags
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            MON_ACTIVE <= 1'b0;
            BAT_CRITICAL <= 1'b0;
        end else if (CE) begin
            MON_ACTIVE <= mon_en_ff;
            BAT_CRITICAL <= crit_ff;
        end
    end

    // State flags decoded from the next state so they change with state_ff
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            IN_STANDBY <= 1'b0;
            IN_MONITOR <= 1'b0;
            IN_HPD <= 1'b1;
        end else if (CE) begin
            IN_STANDBY <= (nxt_state == PSSQ_STANDBY);
            IN_MONITOR <= (nxt_state == PSSQ_MONITOR);
            IN_HPD <= (nxt_state == PSSQ_HPD);
        end
    end

    // One-cycle pulse on the Standby to Active step only
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            WAKEUP_EVENT <= 1'b0;
        end else if (CE) begin
            WAKEUP_EVENT <= (state_ff == PSSQ_STANDBY) && (nxt_state == PSSQ_ACTIVE);
        end
    end

    // Pad supply loss is flagged so the host can reboot; device keeps running
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            PAD_LOST <= 1'b0;
        end else if (CE) begin
            // Clear wins: a drop while disabled needs no reboot
            if (!en_s) begin
                PAD_LOST <= 1'b0;
            end else if (!pad_ok_s) begin
                PAD_LOST <= 1'b1;
            end
        end
    end

    // ****************************************
    // Config memory write pacing
    // ****************************************
    logic wr_pend_ff;

    // Writes wait for the next low-freq tick so timing is oscillator-based
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            wr_pend_ff <= 1'b0;
            NVM_WRITE_STROBE <= 1'b0;
        end else if (CE) begin
            NVM_WRITE_STROBE <= 1'b0;
            // A request racing a reset entry is dropped, so no strobe lands in reset
            if (CORE_RESET || core_rst_nxt) begin
                wr_pend_ff <= 1'b0;
            end else if (wr_pend_ff && LOW_FREQ_OSC_TICK) begin
                NVM_WRITE_STROBE <= 1'b1;
                wr_pend_ff <= NVM_WRITE_REQ;
            end else if (NVM_WRITE_REQ) begin
                wr_pend_ff <= 1'b1;
            end
        end
    end
endmodule

// ### pssq_props.sv
// Checker: port-level properties of the power-state sequencer
`timescale 1ns/100ps
module pssq_props (
    input wire logic REF_CLK, // Clock
    input wire logic SRST, // Reset
    input wire logic CHIP_ENABLE_PIN, // Enable pin
    input wire logic CFG_LOADED, // Load done
    input wire logic CFG_MON_EN, // Supervision cfg
    input wire logic LOW_FREQ_OSC_TICK, // Slow tick
    input wire logic CORE_RESET, // Reset out
    input wire logic CFG_LOAD_REQ, // Reload
    input wire logic NVM_WRITE_STROBE, // Write strobe
    input wire logic MON_ACTIVE, // Supervising
    input wire logic BAT_CRITICAL, // Low battery
    input wire logic IN_STANDBY, // Standby
    input wire logic IN_MONITOR, // Monitor
    input wire logic IN_HPD, // Power down
    input wire logic WAKEUP_EVENT // Wake pulse
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);
    // ********
    // Reset entry and exit, supervision, wake-up and write strobe
    // ********
    property p_hpd; $fell(CHIP_ENABLE_PIN) |-> ##[1:5] (IN_HPD && CORE_RESET); endproperty
    a_hpd: assert property (p_hpd) else $error("no power down after enable low");
    property p_rst; $fell(CORE_RESET) |-> CFG_LOAD_REQ && !IN_HPD && !IN_MONITOR; endproperty
    a_rst: assert property (p_rst) else $error("reset exit without default reload");
    property p_exit; $fell(CORE_RESET) |-> CHIP_ENABLE_PIN && $past(CHIP_ENABLE_PIN, 2); endproperty
    a_exit: assert property (p_exit) else $error("left reset with enable low");
    property p_load; $rose(CHIP_ENABLE_PIN) |-> ##[2:5] CFG_LOAD_REQ; endproperty
    a_load: assert property (p_load) else $error("no reload after enable high");
    // Supervision only after a load that asked for it
    property p_mon; $rose(MON_ACTIVE) |-> $past(CFG_LOADED, 2) && $past(CFG_MON_EN, 2); endproperty
    a_mon: assert property (p_mon) else $error("supervision on without config");
    property p_crit; $rose(BAT_CRITICAL) && MON_ACTIVE && CHIP_ENABLE_PIN |-> ##[0:3] IN_MONITOR; endproperty
    a_crit: assert property (p_crit) else $error("low battery without monitor");
    property p_wake; WAKEUP_EVENT |-> !IN_STANDBY && $past(IN_STANDBY) ##1 !WAKEUP_EVENT; endproperty
    a_wake: assert property (p_wake) else $error("bad wake pulse");
    property p_nvm; NVM_WRITE_STROBE |-> $past(LOW_FREQ_OSC_TICK) && !CORE_RESET; endproperty
    a_nvm: assert property (p_nvm) else $error("write strobe off slow tick");
    c_mon: cover property ($rose(IN_MONITOR));
    c_wake: cover property (WAKEUP_EVENT);
    c_nvm: cover property (NVM_WRITE_STROBE);
endmodule

// ### pssq_host_model.sv
// Host model: supplies and chip-enable pin on the far side
`timescale 1ns/100ps
module pssq_host_model (
    input wire logic clk, // System clock
    input wire logic power_on, // Host wants device up
    input wire logic pad_cut, // Pad supply dropped
    input wire logic slow, // Host answers late
    input wire logic pad_lost, // Device flag
    output logic bat_ok = 1'b0, // Battery present
    output logic pad_ok = 1'b0, // Pad supply present
    output logic en_pin = 1'b0 // Chip-enable level
);
    int wait_n = 0;
    // ********
    // Supplies first, enable only once the battery is up
    // ********
    always @(posedge clk) begin
        bat_ok <= power_on;
        pad_ok <= power_on && !pad_cut;
        if (!bat_ok || !power_on) begin
            en_pin <= 1'b0;
            wait_n <= slow ? 20 : 2;
        end else if (pad_lost && pad_ok && en_pin) begin
            en_pin <= 1'b0;
            wait_n <= 6;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else begin
            en_pin <= 1'b1;
        end
    end
endmodule

// ### pssq_tb_top.sv
// Testbench: host-driven scenarios for the power-state sequencer
`timescale 1ns/100ps
module pssq_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic b23 = 1'b0;
    logic b275 = 1'b0;
    logic tick = 1'b0;
    logic mon_en = 1'b0;
    logic thr = 1'b0;
    logic loaded = 1'b0;
    logic sby = 1'b0;
    logic nvm = 1'b0;
    logic pwr = 1'b0;
    logic cut = 1'b0;
    logic slow = 1'b0;
    logic en, bok, pok, crst, ldreq, strb, mact, bcrit, isby, imon, ihpd, wev, plost;
    int n_mismatch = 0;
    int checks = 0;
    int tcnt = 0;
    always #10 clk = ~clk;
    // Slow oscillator stand-in, one tick per 53 cycles
    always @(posedge clk) begin
        tcnt <= (tcnt == 52) ? 0 : tcnt + 1;
        tick <= (tcnt == 52);
    end
    pssq_top pssq_top_i (.REF_CLK(clk), .SRST(srst), .CE(ce), .CHIP_ENABLE_PIN(en), .BAT_BELOW_2V3(b23),
        .BAT_BELOW_2V75(b275), .BAT_SUPPLY_OK(bok), .PAD_SUPPLY_OK(pok), .LOW_FREQ_OSC_TICK(tick),
        .CFG_MON_EN(mon_en), .CFG_THR_SEL(thr), .CFG_LOADED(loaded), .STANDBY_REQ(sby),
        .WAKEUP_PERIOD(16'h0003), .NVM_WRITE_REQ(nvm), .CORE_RESET(crst), .CFG_LOAD_REQ(ldreq),
        .NVM_WRITE_STROBE(strb), .MON_ACTIVE(mact), .BAT_CRITICAL(bcrit), .IN_STANDBY(isby),
        .IN_MONITOR(imon), .IN_HPD(ihpd), .WAKEUP_EVENT(wev), .PAD_LOST(plost));
    pssq_host_model pssq_host_model_i (.clk(clk), .power_on(pwr), .pad_cut(cut), .slow(slow),
        .pad_lost(plost), .bat_ok(bok), .pad_ok(pok), .en_pin(en));
    // ********
    // Shared helpers
    // ********
    task chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait; running out shows up as a mismatch
    task automatic wt(ref logic s, input logic v, input int n);
        repeat (n) begin
            cy(1);
            if (s === v) break;
        end
        chk(s, v);
    endtask
    task bat(input logic lo, input logic hi);
        @(posedge clk);
        b23 <= lo;
        b275 <= hi;
    endtask
    task boot(input logic m, input logic t);
        wt(ldreq, 1'b1, 40);
        chk(ihpd, 1'b0);
        @(posedge clk);
        mon_en <= m;
        thr <= t;
        loaded <= 1'b1;
        @(posedge clk);
        loaded <= 1'b0;
        wt(ldreq, 1'b0, 10);
        wt(crst, 1'b0, 4);
        chk(mact, m);
    endtask
    task give_verdict;
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    // Unsupervised: a dead battery must not reset the core
    task t_unsup;
        boot(1'b0, 1'b0);
        bat(1'b1, 1'b1);
        cy(8);
        chk(imon, 1'b0);
        chk(crst, 1'b0);
        chk(bcrit, 1'b0);
        bat(1'b0, 1'b0);
    endtask
    // 2.5 V trips only the high threshold; 2.0 V trips both
    task t_monitor(input logic t);
        bat(1'b0, 1'b1);
        cy(8);
        chk(imon, t);
        chk(bcrit, t);
        bat(1'b1, 1'b1);
        wt(imon, 1'b1, 8);
        chk(crst, 1'b1);
        bat(1'b0, 1'b0);
        boot(1'b1, !t);
    endtask
    task t_standby;
        @(posedge clk);
        sby <= 1'b1;
        @(posedge clk);
        sby <= 1'b0;
        wt(isby, 1'b1, 4);
        cy(53);
        chk(isby, 1'b1);
        wt(wev, 1'b1, 300);
        cy(1);
        chk(isby, 1'b0);
    endtask
    // Request held until the strobe, which must follow a slow tick
    task t_nvm;
        @(posedge clk);
        nvm <= 1'b1;
        wt(strb, 1'b1, 60);
        chk(tcnt == 1, 1'b1);
        @(posedge clk);
        nvm <= 1'b0;
    endtask
    task t_pad;
        @(posedge clk);
        cut <= 1'b1;
        wt(plost, 1'b1, 10);
        @(posedge clk);
        cut <= 1'b0;
        wt(crst, 1'b1, 20);
        boot(1'b1, 1'b0);
    endtask
    task t_down;
        @(posedge clk);
        pwr <= 1'b0;
        wt(ihpd, 1'b1, 10);
        chk(crst, 1'b1);
        wt(mact, 1'b0, 4);
    endtask
    // Reload with no loader pulse ends on the bounded wait; clock enable low stalls it
    task t_selfload;
        wt(ldreq, 1'b1, 40);
        @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        cy(7);
        chk(ldreq, 1'b1);
        cy(1);
        chk(ldreq, 1'b0);
        chk(mact, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        cy(1);
        chk(ihpd, 1'b1);
        chk(mact, 1'b0);
        slow <= 1'b1;
        pwr <= 1'b1;
        t_unsup;
        t_down;
        slow <= 1'b0;
        pwr <= 1'b1;
        boot(1'b1, 1'b0);
        t_monitor(1'b0);
        t_monitor(1'b1);
        t_standby;
        t_nvm;
        t_pad;
        t_down;
        pwr <= 1'b1;
        t_selfload;
        give_verdict;
    end
    // Whole run needs under a thousand cycles; the limit allows 10000
    initial begin
        #200000;
        n_mismatch++;
        give_verdict;
    end
endmodule
bind pssq_top pssq_props pssq_props_i (.*);
